//--- dv/pcg_ref_src.sv
// Far-side model: reference clock source and analog lock flag.
// Assumes the bench clock and the power-down pin level.
`timescale 1ns/1ns
`default_nettype none
module pcg_ref_src (
   input wire logic clk,
   input wire logic powerDown_n,
   output logic refClk,
   output logic pllLock
);
   int lockCnt = 0;
   ////////////////////////////////////////////////////////////////////////
   // 22.7 MHz, odd-ns edges so they never meet a clk edge
   initial begin
      refClk = 1'b0;
      #1;
      forever #22 refClk = ~refClk;
   end
   // Lock some time after power-up, lost at once on power-down
   always @(posedge clk or negedge powerDown_n) begin
      if (!powerDown_n) begin
         lockCnt <= 0;
      end else if (lockCnt < 40) begin
         lockCnt <= lockCnt + 1;
      end
   end
   assign pllLock = (lockCnt == 40);
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench of the clock output control over APB.
// Assumes the far-side model and a short settle count.
`timescale 1ns/1ns
`default_nettype none
module tb;
   import pcg_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, powerDown_n = 1'b0;
   logic refClk, pllLock, outA, outB, outC, refSel, capEn, gainEn, diffEn;
   logic ssAct, er;
   logic [8:0] loadCode;
   logic [5:0] drive;
   logic [2:0] refHist;
   logic [31:0] rd;
   pcg_diff_std_t diffStd;
   pcg_apb_req_t req = '0;
   pcg_apb_rsp_t rsp;
   int failures = 0, nTests = 0;
   pcg_top #(.SETTLE_CYCLES(8)) i_dut (.clk(clk), .rst_n(rst_n),
      .apbReq(req), .apbRsp(rsp), .powerDown_n(powerDown_n),
      .referenceInput(refClk), .pllLock(pllLock), .outClockA(outA),
      .outClockB(outB), .outClockC(outC), .referenceSelect(refSel),
      .internalCapEnable(capEn), .crystalLoadCode(loadCode),
      .crystalGainControlEn(gainEn), .diffEnable(diffEn),
      .diffStandard(diffStd), .outDrive(drive), .spreadActive(ssAct));
   pcg_ref_src i_src (.clk(clk), .powerDown_n(powerDown_n),
      .refClk(refClk), .pllLock(pllLock));
   initial forever #2 clk = ~clk;
   always @(posedge clk) refHist <= {refHist[1:0], refClk};
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      apb(1'b0, ADDR_INPUT, '0);
      chk(rd, 32'h061A_8000);
      chk(32'({capEn, gainEn, outA, outB, outC}), 32'h18);
      apb(1'b0, 8'h40, '0);
      chk(32'(er), 32'h1);
   endtask
   task automatic t_load();
      apb(1'b1, ADDR_INPUT, 32'h061A_8FFA);
      wt(2);
      chk(32'({capEn, loadCode}), 32'h140);
      apb(1'b1, ADDR_INPUT, 32'h061A_8A04);
      wt(2);
      chk(32'(capEn), 32'h1);
      apb(1'b1, ADDR_INPUT, 32'h061A_8A05);
      wt(2);
      chk(32'({refSel, capEn, gainEn}), 32'h4);
      apb(1'b1, ADDR_INPUT, 32'h061A_8000);
   endtask
   // Over-range fields come back clamped
   task automatic t_spread();
      apb(1'b1, ADDR_SPREAD, 32'h0000_C8FF);
      apb(1'b0, ADDR_SPREAD, '0);
      chk(rd, 32'h0000_8243);
      apb(1'b1, ADDR_SPREAD, 32'h0000_01FD);
      apb(1'b0, ADDR_SPREAD, '0);
      chk(rd, 32'h0000_1E61);
      wt(1);
      chk(32'(ssAct), 32'h1);
   endtask
   task automatic t_diff();
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, ADDR_OUTPUT, 32'h0200_1301 | 32'(s << 1));
         wt(2);
         chk(32'(diffStd), 32'(s));
      end
      chk(32'({diffEn, drive}), 32'h63);
      @(posedge clk);
      powerDown_n <= 1'b1;
      wt(10);
      chk(32'({outA, outB, outC}), 32'h2);
   endtask
   // Pair runs complementary, then C alone as inverted bypass copy
   task automatic t_run();
      int togg, hit, bad;
      logic last;
      togg = 0;
      hit = 0;
      bad = 0;
      wt(80);
      last = outA;
      repeat (200) begin
         wt(1);
         togg += int'(outA !== last);
         last = outA;
         bad += int'(outB !== ~outA);
      end
      chk(32'(togg > 10), 32'h1);
      chk(32'(bad), 32'h0);
      apb(1'b1, ADDR_OUTPUT, 32'h1E00_0000);
      wt(4);
      repeat (200) begin
         wt(1);
         hit += int'(outC === ~refHist[2]);
         bad += int'((outA | outB) !== 1'b0);
      end
      chk(32'(hit > 150), 32'h1);
      chk(32'(bad), 32'h0);
   endtask
   task automatic t_pd();
      @(posedge clk);
      powerDown_n <= 1'b0;
      @(negedge clk);
      chk(32'({outA, outB, outC}), 32'h0);
      apb(1'b0, ADDR_OUTPUT, '0);
      chk(rd, 32'h1E00_0000);
   endtask
   // Clamps and warning flag, then burn freezes config until reset
   task automatic t_burn();
      apb(1'b1, ADDR_FREQ_A, 32'h0000_0003);
      apb(1'b0, ADDR_FREQ_A, '0);
      chk(rd, 32'h0000_0008);
      apb(1'b1, ADDR_SPREAD, 32'h0000_8201);
      apb(1'b0, ADDR_SPREAD, '0);
      chk(rd, 32'h0000_8205);
      apb(1'b0, ADDR_STATUS, '0);
      chk(rd, 32'h0000_0040);
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      apb(1'b1, ADDR_FREQ_B, 32'h0000_0100);
      chk(32'(er), 32'h1);
      apb(1'b0, ADDR_FREQ_B, '0);
      chk(rd, 32'h0000_5DC0);
      // Only a reset lifts the burn
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, ADDR_CTRL, '0);
      chk(rd, 32'h0000_0000);
   endtask
   task automatic give_verdict();
      if (failures == 0 && nTests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_load();
      t_spread();
      t_diff();
      t_run();
      t_pd();
      t_burn();
      give_verdict();
   end
   // Whole run takes about 600 cycles
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      give_verdict();
   end
endmodule
`default_nettype wire

//--- src/pcg_out_gen.sv
// One synthesized output: phase accumulator with spread offset.
// Assumes step and spread inputs come from registers on the same clock.
`timescale 1ns/1ns
`default_nettype none
module pcg_out_gen (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [31:0] step,
   input wire logic [7:0] triPos,
   input wire logic ssOn,
   input wire logic ssDown,
   input wire logic [5:0] devEighths,
   output logic phaseBit
);
   import pcg_pkg::*;

   typedef struct packed {
      logic [31:0] acc;
   } pcg_gen_state_t;

   pcg_gen_state_t st, next_st;
   logic [28:0] span;
   logic signed [39:0] spanS, triS, prod, offs, sum;

   ////////////////////////////////////////////////////////////////////////
   // Triangle offset: centred or below nominal; bypass never gets here
   always_comb begin
      next_st = st;
      span = 29'(32'(step[31:15]) * 32'(DEV_SCALE) * 32'(devEighths));
      spanS = $signed({11'h000, span});
      triS = $signed({32'h0, triPos});
      if (!ssDown) begin
         triS = triS - 40'sh80;
      end
      prod = spanS * triS;
      if (!ssOn) begin
         offs = 40'sh0;
      end else if (ssDown) begin
         offs = -(prod >>> 8);
      end else begin
         offs = prod >>> 7;
      end
      sum = $signed({8'h00, step}) + offs;
      next_st.acc = run ? st.acc + sum[31:0] : 32'h0;
   end

   // Accumulator register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign phaseBit = st.acc[31];
endmodule
`default_nettype wire

//--- src/pcg_pkg.sv
// Shared constants, field layouts and carriers of the clock output control.
// Assumes a 250 MHz system clock and a 32-bit APB register port.
package pcg_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_HZ = 250000000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int SETTLE_NS = 20000;
   localparam int SETTLE_CYCLES = SETTLE_NS / CLK_PERIOD_NS;
   // Phase step per kHz of output: round(2^32 * 1000 / CLK_HZ)
   localparam logic [14:0] STEP_PER_KHZ =
      15'(((64'h1 << 32) * 64'h3E8 + 64'(CLK_HZ / 2)) / 64'(CLK_HZ));
   // Deviation scale: 2^15 / 800 per eighth of a percent
   localparam logic [5:0] DEV_SCALE = 6'h29;

   ////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [7:0] ADDR_INPUT = 8'h00;
   localparam logic [7:0] ADDR_OUTPUT = 8'h04;
   localparam logic [7:0] ADDR_FREQ_A = 8'h08;
   localparam logic [7:0] ADDR_FREQ_B = 8'h0C;
   localparam logic [7:0] ADDR_FREQ_C = 8'h10;
   localparam logic [7:0] ADDR_SPREAD = 8'h14;
   localparam logic [7:0] ADDR_CTRL = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;

   // Field positions
   localparam int IN_REFSEL_BIT = 0;
   localparam int IN_LOAD_LSB = 1;
   localparam int IN_CAP_LSB = 3;
   localparam int IN_FREQ_LSB = 12;
   localparam int OUT_DIFF_BIT = 0;
   localparam int OUT_STD_LSB = 1;
   localparam int OUT_CH_LSB = 8;
   localparam int OUT_CH_STRIDE = 8;
   localparam int SS_ON_BIT = 0;
   localparam int SS_DOWN_BIT = 1;
   localparam int SS_DEV_LSB = 2;
   localparam int SS_RATE_LSB = 8;
   localparam int CTRL_BURN_BIT = 0;

   ////////////////////////////////////////////////////////////////////////
   // Limits, in kHz, hundredths of a pF and deviation steps
   localparam int CAP_MIN_CPF = 436;
   localparam int CAP_MAX_CPF = 2039;
   localparam int CAP_STEP_CPF = 5;
   localparam logic [8:0] CAP_CODE_MAX =
      9'((CAP_MAX_CPF - CAP_MIN_CPF) / CAP_STEP_CPF);
   localparam logic [17:0] FREQ_MIN_KHZ = 18'h00008;
   localparam logic [17:0] FREQ_MAX_KHZ = 18'h30D40;
   localparam logic [17:0] IN_MIN_KHZ = 18'h00BB8;
   localparam logic [17:0] XTAL_MAX_KHZ = 18'h0C350;
   localparam logic [17:0] REF_MAX_KHZ = 18'h30D40;
   localparam logic [17:0] SS_FIN_MIN_KHZ = 18'h01A5E;
   localparam logic [17:0] SS_RATE_RATIO = 18'h000E1;
   localparam logic [5:0] DEV_CENTER_MAX = 6'h18;
   localparam logic [5:0] DEV_DOWN_MAX = 6'h10;
   localparam logic [5:0] DEV_MIN = 6'h01;
   localparam logic [7:0] RATE_MIN_KHZ = 8'h1E;
   localparam logic [7:0] RATE_MAX_KHZ = 8'h82;

   ////////////////////////////////////////////////////////////////////////
   // Enumerations
   typedef enum logic [1:0] {
      LOAD_INTERNAL = 2'b00, LOAD_EXTERNAL = 2'b01, LOAD_BOTH = 2'b10
   } pcg_load_t;
   typedef enum logic [1:0] {
      STD_LVPECL = 2'b00, STD_LVDS = 2'b01, STD_HCSL = 2'b10, STD_CML = 2'b11
   } pcg_diff_std_t;
   typedef enum logic [1:0] {
      RUN_OFF = 2'b00, RUN_LOCK = 2'b01, RUN_SETTLE = 2'b10, RUN_ON = 2'b11
   } pcg_run_t;

   // Carriers
   typedef struct packed {
      logic enable;
      logic bypass;
      logic invert;
      logic [1:0] drive;
   } pcg_out_cfg_t;
   typedef struct packed {
      logic refSel;
      pcg_load_t loadMode;
      logic [8:0] capCode;
      logic [17:0] inFreqKhz;
      logic diffMode;
      pcg_diff_std_t diffStd;
      pcg_out_cfg_t [2:0] outs;
      logic [2:0][17:0] freqKhz;
      logic ssOn;
      logic ssDown;
      logic [5:0] devCode;
      logic [7:0] rateKhz;
   } pcg_cfg_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } pcg_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pcg_apb_rsp_t;

   localparam pcg_cfg_t CFG_RESET = '{
      refSel: 1'b0, loadMode: LOAD_INTERNAL, capCode: 9'h000,
      inFreqKhz: 18'h061A8, diffMode: 1'b0, diffStd: STD_LVDS,
      outs: '0, freqKhz: {3{18'h05DC0}}, ssOn: 1'b0, ssDown: 1'b0,
      devCode: 6'h01, rateKhz: 8'h1E};

endpackage

//--- src/pcg_top.sv
// Configuration and output control of the programmable clock generator.
// Assumes an APB master on clk; pins arrive asynchronous to clk.
//
// How it works
// - Input is crystal 3-50 MHz or single-ended reference 3-200 MHz.
// - Internal load capacitance code spans 4.36 to 20.36 pF, 0.05 pF.
// - Crystal load: internal only, external only, or both together.
// - External reference selected switches internal load caps out.
// - Three single-ended outputs, or A/B as one differential pair.
// - Each output frequency set from 8 kHz to 200 MHz.
// - Each single-ended output picks one of four drive levels.
// - Each output may carry a buffered copy of the input clock.
// - Each output may be inverted, bypassed outputs included.
// - Spread: centre 0.125-3% by 0.125%, or down 0.25-4% by 0.25%.
// - Modulation rate set from 30 kHz to 130 kHz.
// - Spread applies to all PLL outputs, never to bypassed ones.
// - Power-down pin low asynchronously forces outputs low; config is kept.
// - Power-down defaults to active; outside must drive it high.
// - Exactly one stored configuration holds every setting.
// - Before lock and settle: PLL outputs low, pair held low/high.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module pcg_top #(
   parameter int SETTLE_CYCLES = pcg_pkg::SETTLE_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire pcg_pkg::pcg_apb_req_t apbReq,
   output pcg_pkg::pcg_apb_rsp_t apbRsp,
   input wire logic powerDown_n,
   input wire logic referenceInput,
   input wire logic pllLock,
   output logic outClockA,
   output logic outClockB,
   output logic outClockC,
   output logic referenceSelect,
   output logic internalCapEnable,
   output logic [8:0] crystalLoadCode,
   output logic crystalGainControlEn,
   output logic diffEnable,
   output pcg_pkg::pcg_diff_std_t diffStandard,
   output logic [5:0] outDrive,
   output logic spreadActive
);
   import pcg_pkg::*;

   typedef struct packed {
      logic [1:0] pdSync;
      logic [1:0] lockSync;
      logic [1:0] refSync;
      pcg_run_t run;
      logic [15:0] settleCnt;
      logic burned;
      pcg_cfg_t cfg;
      pcg_apb_rsp_t rsp;
      logic intCapEn;
      logic agcEn;
      logic inRangeErr;
      logic ssWarn;
      logic [31:0] modAcc;
   } pcg_top_state_t;

   pcg_top_state_t st, next_st;
   logic [2:0] genBit, pinNext;
   logic [2:0][31:0] stepWord;
   logic [7:0] triPos;
   logic [5:0] devEighths;
   logic setup, access, cfgAddr, live;
   logic [7:0] a;
   logic [31:0] w;

   // Out-of-range values land on the nearest legal setting
   function automatic logic [17:0] clampFreq(input logic [17:0] f);
      if (f < FREQ_MIN_KHZ) begin
         return FREQ_MIN_KHZ;
      end else if (f > FREQ_MAX_KHZ) begin
         return FREQ_MAX_KHZ;
      end
      return f;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Tuning words and the shared modulation triangle
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         stepWord[i] = 32'(st.cfg.freqKhz[i] * STEP_PER_KHZ);
      end
      triPos = st.modAcc[31] ? ~st.modAcc[30:23] : st.modAcc[30:23];
      // Down steps are twice as coarse as centre steps
      devEighths = st.cfg.ssDown ? 6'(st.cfg.devCode << 1)
                                 : st.cfg.devCode;
   end

   // One generator per output; all share the spread profile
   for (genvar g = 0; g < 3; g++) begin : g_out
      pcg_out_gen u_gen (
         .clk(clk),
         .rst_n(rst_n),
         .run(st.run == RUN_ON),
         .step(stepWord[g]),
         .triPos(triPos),
         .ssOn(st.cfg.ssOn),
         .ssDown(st.cfg.ssDown),
         .devEighths(devEighths),
         .phaseBit(genBit[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state: synchronisers, APB slave, config, run sequence
   always_comb begin
      next_st = st;
      a = apbReq.paddr;
      w = apbReq.pwdata;
      next_st.pdSync = {st.pdSync[0], powerDown_n};
      next_st.lockSync = {st.lockSync[0], pllLock};
      next_st.refSync = {st.refSync[0], referenceInput};
      setup = apbReq.psel && !apbReq.penable;
      access = apbReq.psel && apbReq.penable && st.rsp.pready;
      cfgAddr = (a == ADDR_INPUT) || (a == ADDR_OUTPUT) ||
                (a == ADDR_FREQ_A) || (a == ADDR_FREQ_B) ||
                (a == ADDR_FREQ_C) || (a == ADDR_SPREAD);
      // Answer is prepared in setup so the access phase needs no wait
      next_st.rsp.pready = setup;
      next_st.rsp.pslverr = 1'b0;
      next_st.rsp.prdata = 32'h0;
      if (setup && !apbReq.pwrite) begin
         if (a == ADDR_INPUT) begin
            next_st.rsp.prdata = {2'h0, st.cfg.inFreqKhz, st.cfg.capCode,
                                  st.cfg.loadMode, st.cfg.refSel};
         end else if (a == ADDR_OUTPUT) begin
            next_st.rsp.prdata = {3'h0, st.cfg.outs[2], 3'h0, st.cfg.outs[1],
                                  3'h0, st.cfg.outs[0], 5'h00,
                                  st.cfg.diffStd, st.cfg.diffMode};
         end else if (a == ADDR_FREQ_A) begin
            next_st.rsp.prdata = {14'h0, st.cfg.freqKhz[0]};
         end else if (a == ADDR_FREQ_B) begin
            next_st.rsp.prdata = {14'h0, st.cfg.freqKhz[1]};
         end else if (a == ADDR_FREQ_C) begin
            next_st.rsp.prdata = {14'h0, st.cfg.freqKhz[2]};
         end else if (a == ADDR_SPREAD) begin
            next_st.rsp.prdata = {16'h0, st.cfg.rateKhz, st.cfg.devCode,
                                  st.cfg.ssDown, st.cfg.ssOn};
         end else if (a == ADDR_CTRL) begin
            next_st.rsp.prdata = {31'h0, st.burned};
         end else if (a == ADDR_STATUS) begin
            next_st.rsp.prdata = {25'h0, st.ssWarn, st.inRangeErr, st.burned,
                                  st.lockSync[1], st.pdSync[1], st.run};
         end else begin
            next_st.rsp.pslverr = 1'b1;
         end
      end else if (setup) begin
         // Frozen config refuses writes with an error
         next_st.rsp.pslverr = (st.burned && cfgAddr) || !(cfgAddr ||
            a == ADDR_CTRL || a == ADDR_STATUS);
      end

      // Register writes take effect only at the access edge
      if (access && apbReq.pwrite && !st.burned) begin
         if (a == ADDR_INPUT) begin
            next_st.cfg.refSel = w[IN_REFSEL_BIT];
            next_st.cfg.loadMode = (w[IN_LOAD_LSB +: 2] == 2'h3) ? LOAD_BOTH
               : pcg_load_t'(w[IN_LOAD_LSB +: 2]);
            next_st.cfg.capCode = (w[IN_CAP_LSB +: 9] > CAP_CODE_MAX) ?
               CAP_CODE_MAX : w[IN_CAP_LSB +: 9];
            next_st.cfg.inFreqKhz = w[IN_FREQ_LSB +: 18];
         end else if (a == ADDR_OUTPUT) begin
            next_st.cfg.diffMode = w[OUT_DIFF_BIT];
            next_st.cfg.diffStd = pcg_diff_std_t'(w[OUT_STD_LSB +: 2]);
            for (int i = 0; i < 3; i++) begin
               // Enable, bypass, invert and drive per output
               next_st.cfg.outs[i] =
                  w[OUT_CH_LSB + OUT_CH_STRIDE * i +: 5];
            end
         end else if (a == ADDR_FREQ_A) begin
            next_st.cfg.freqKhz[0] = clampFreq(w[17:0]);
         end else if (a == ADDR_FREQ_B) begin
            next_st.cfg.freqKhz[1] = clampFreq(w[17:0]);
         end else if (a == ADDR_FREQ_C) begin
            next_st.cfg.freqKhz[2] = clampFreq(w[17:0]);
         end else if (a == ADDR_SPREAD) begin
            next_st.cfg.ssOn = w[SS_ON_BIT];
            next_st.cfg.ssDown = w[SS_DOWN_BIT];
            next_st.cfg.devCode = w[SS_DEV_LSB +: 6];
            if (w[SS_DEV_LSB +: 6] < DEV_MIN) begin
               next_st.cfg.devCode = DEV_MIN;
            end else if (w[SS_DOWN_BIT] &&
                         w[SS_DEV_LSB +: 6] > DEV_DOWN_MAX) begin
               next_st.cfg.devCode = DEV_DOWN_MAX;
            end else if (!w[SS_DOWN_BIT] &&
                         w[SS_DEV_LSB +: 6] > DEV_CENTER_MAX) begin
               next_st.cfg.devCode = DEV_CENTER_MAX;
            end
            next_st.cfg.rateKhz = w[SS_RATE_LSB +: 8];
            if (w[SS_RATE_LSB +: 8] < RATE_MIN_KHZ) begin
               next_st.cfg.rateKhz = RATE_MIN_KHZ;
            end else if (w[SS_RATE_LSB +: 8] > RATE_MAX_KHZ) begin
               next_st.cfg.rateKhz = RATE_MAX_KHZ;
            end
         end else if (a == ADDR_CTRL) begin
            next_st.burned = w[CTRL_BURN_BIT];
         end
      end

      // Static controls to the analog side, one cycle behind config
      next_st.intCapEn = !st.cfg.refSel &&
                         st.cfg.loadMode != LOAD_EXTERNAL;
      next_st.agcEn = !st.cfg.refSel;
      next_st.inRangeErr = st.cfg.inFreqKhz < IN_MIN_KHZ ||
         st.cfg.inFreqKhz > (st.cfg.refSel ? REF_MAX_KHZ
                                           : XTAL_MAX_KHZ);
      // Flag profiles the PLL may not track; nothing is blocked
      next_st.ssWarn = st.cfg.ssOn && (st.cfg.inFreqKhz < SS_FIN_MIN_KHZ ||
         18'({10'h000, st.cfg.rateKhz} * SS_RATE_RATIO) >
         st.cfg.inFreqKhz);
      next_st.modAcc = (st.run == RUN_ON) ?
         st.modAcc + 32'(st.cfg.rateKhz * STEP_PER_KHZ) : 32'h0;

      // Lock and settle sequence
      case (st.run)
         RUN_OFF: begin
            next_st.run = RUN_LOCK;
         end
         RUN_LOCK: begin
            next_st.settleCnt = 16'h0000;
            if (st.lockSync[1]) begin
               next_st.run = RUN_SETTLE;
            end
         end
         RUN_SETTLE: begin
            next_st.settleCnt = st.settleCnt + 16'h0001;
            if (!st.lockSync[1]) begin
               next_st.run = RUN_LOCK;
            end else if (st.settleCnt ==
                         16'(SETTLE_CYCLES - 1)) begin
               next_st.run = RUN_ON;
            end
         end
         default: begin
            if (!st.lockSync[1]) begin
               next_st.run = RUN_LOCK;
            end
         end
      endcase
      if (!st.pdSync[1]) begin
         next_st.run = RUN_OFF;
         next_st.modAcc = 32'h0;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
         st.cfg <= CFG_RESET;
         st.run <= RUN_OFF;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output pin selection
   always_comb begin
      live = 1'b0;
      for (int i = 0; i < 3; i++) begin
         // Bypass needs no lock; PLL outputs wait for settle
         live = st.cfg.outs[i].enable && (st.cfg.outs[i].bypass ?
            st.pdSync[1] : st.run == RUN_ON);
         pinNext[i] = live && ((st.cfg.outs[i].bypass ? st.refSync[1]
            : genBit[i]) ^ st.cfg.outs[i].invert);
      end
      if (st.cfg.diffMode) begin
         // Pair: B is A's complement while A is enabled; both low if A is disabled
         pinNext[1] = st.cfg.outs[0].enable && !pinNext[0];
      end
   end

   // Pin flops clear at once when power-down falls
   always_ff @(posedge clk or negedge powerDown_n) begin
      if (!powerDown_n) begin
         {outClockC, outClockB, outClockA} <= 3'h0;
      end else if (!rst_n) begin
         {outClockC, outClockB, outClockA} <= 3'h0;
      end else begin
         {outClockC, outClockB, outClockA} <= pinNext;
      end
   end

   assign apbRsp = st.rsp;
   assign referenceSelect = st.cfg.refSel;
   assign internalCapEnable = st.intCapEn;
   assign crystalLoadCode = st.cfg.capCode;
   assign crystalGainControlEn = st.agcEn;
   assign diffEnable = st.cfg.diffMode;
   assign diffStandard = st.cfg.diffStd;
   assign outDrive = {st.cfg.outs[2].drive, st.cfg.outs[1].drive,
                      st.cfg.outs[0].drive};
   assign spreadActive = st.cfg.ssOn;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_setup;
      apbReq.psel && !apbReq.penable;
   endsequence
   sequence s_wr_access;
      apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
   endsequence

   a_apb_zero_wait:
   assert property (s_setup ##1 apbReq.penable |-> apbRsp.pready ##1
                    !apbRsp.pready)
      else $error("access phase not answered in one cycle");
   a_burn_freezes:
   assert property (st.burned ##0 s_wr_access |=> $stable(st.cfg))
      else $error("config changed after burn");
   a_pd_low:
   assert property (!powerDown_n && $past(!powerDown_n) |->
                    {outClockA, outClockB, outClockC} == 3'h0)
      else $error("outputs not low in power-down");
   a_prelock_low:
   assert property ($past(rst_n) && $past(powerDown_n) && powerDown_n &&
                    $past(st.run != RUN_ON && !st.cfg.outs[2].bypass)
                    |-> !outClockC)
      else $error("output active before settle");
   a_pair_static:
   assert property ($past(rst_n) && $past(powerDown_n) && powerDown_n &&
                    $past(st.cfg.diffMode && st.cfg.outs[0].enable &&
                    !st.cfg.outs[0].bypass && st.run != RUN_ON)
                    |-> !outClockA && outClockB)
      else $error("pair not held low/high before settle");
   a_disabled_low:
   assert property ($past(rst_n) && $past(!st.cfg.outs[2].enable)
                    |-> !outClockC)
      else $error("disabled output toggles");
   a_bypass_copy:
   assert property ($past(rst_n) && $past(powerDown_n) && powerDown_n &&
                    $past(st.cfg.outs[2].enable && st.cfg.outs[2].bypass &&
                    st.pdSync[1]) |-> outClockC ==
                    ($past(st.refSync[1]) ^ $past(st.cfg.outs[2].invert)))
      else $error("bypass output is not the input copy");
   a_ext_ref_caps:
   assert property (st.cfg.refSel [*2] |-> !internalCapEnable)
      else $error("internal caps left on with reference input");
   a_cap_clamp:
   assert property (s_wr_access ##0 (apbReq.paddr == ADDR_INPUT) &&
                    !st.burned && apbReq.pwdata[IN_CAP_LSB +: 9] >
                    CAP_CODE_MAX |=> crystalLoadCode == CAP_CODE_MAX)
      else $error("load code not clamped");
   a_freq_clamp:
   assert property (s_wr_access ##0 (apbReq.paddr == ADDR_FREQ_A) &&
                    !st.burned && apbReq.pwdata[17:0] < FREQ_MIN_KHZ
                    |=> st.cfg.freqKhz[0] == FREQ_MIN_KHZ)
      else $error("frequency not clamped");
   a_dev_range:
   assert property (st.cfg.devCode >= DEV_MIN && st.cfg.devCode <=
                    (st.cfg.ssDown ? DEV_DOWN_MAX : DEV_CENTER_MAX))
      else $error("deviation out of range");
   a_rate_range:
   assert property (st.cfg.rateKhz >= RATE_MIN_KHZ &&
                    st.cfg.rateKhz <= RATE_MAX_KHZ)
      else $error("modulation rate out of range");
endmodule
`default_nettype wire
